//--- logic/spc_defines.svh
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// Interface address decode
`define SPC_ADDR_HOLD0      4'h0
`define SPC_ADDR_HOLD3      4'h3
`define SPC_ADDR_RDPTR      4'h8
`define SPC_ADDR_LOGIC_CMD  4'h9
`define SPC_ADDR_RELEARN    4'hf
// Command bytes and logic command values
`define SPC_RELEARN_BYTE    8'hff
`define SPC_LEARN_BYTE      8'h01
`define SPC_CMD_READBACK    4'h5
`define SPC_CMD_LOAD_CAL    4'h0
`define SPC_CMD_READ_CAL    4'h3
// Configuration word fields
`define SPC_CFG_TRIM_HI     15
`define SPC_CFG_TRIM_LO     13
`define SPC_CFG_CLIP_HI     12
`define SPC_CFG_CLIP_LO     11
`define SPC_CFG_INV         10
`define SPC_CFG_COARSE_OFFSET_POLARITY    9
`define SPC_CFG_IRO_HI      8
`define SPC_CFG_IRO_LO      6
`define SPC_CFG_GAIN_HI     5
`define SPC_CFG_GAIN_LO     2
`define SPC_CFG_OFFSET_DAC_POLARITY   1
`define SPC_CFG_OTC_SIGN    0
`define SPC_CFG_RESET       16'h0000
// Gain figures in V/V
`define SPC_GAIN_BASE       8'd39
`define SPC_GAIN_STEP       8'd13
// Lookup addressing
`define SPC_OFFSET_DAC_VALUE_LOW_BASE   10'h000
`define SPC_OFFSET_DAC_VALUE_HIGH_BASE  10'h100
`define SPC_SPAN_LOW_BASE   10'h200
`define SPC_SPAN_HIGH_BASE  10'h1a0
`define SPC_PTR_SPLIT       8'h80
// Bit periods per frame (start, 8 data, stop)
`define SPC_FRAME_BITS      4'd10

`endif

//--- logic/spc_pkg.sv
package spc_pkg;
    typedef enum logic [3:0] {
        SPC_RX_LEARN_IDLE  = 4'b0000,
        SPC_RX_LEARN_START = 4'b0001,
        SPC_RX_IDLE        = 4'b0010,
        SPC_RX_DATA        = 4'b0011,
        SPC_RX_STOP        = 4'b0100,
        SPC_TX_WAIT        = 4'b0101,
        SPC_TX_PRE         = 4'b0110,
        SPC_TX_BITS        = 4'b0111,
        SPC_TX_GAP         = 4'b1000
    } spc_state_e;
endpackage

//--- logic/spc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface spc_link_if;
    logic       tick;
    logic [7:0] period;
    logic       restart;
    modport owner (output tick, input period, input restart);
    modport user  (input tick, output period, output restart);
endinterface
`default_nettype wire

//--- logic/spc_bit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module spc_bit_timer
    import spc_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    spc_link_if.owner       link
);
    typedef struct packed
    {
        logic [7:0] cnt;
        logic       tick;
    } spc_timer_s;

    spc_timer_s timer_reg;
    spc_timer_s timer_next;

    // One-cycle pulse every learned bit period; restart aligns phase
    always_comb
    begin
        timer_next      = timer_reg;
        timer_next.tick = 1'b0;
        if (link.restart)
        begin
            timer_next.cnt = 8'h01;
        end
        else if (timer_reg.cnt >= link.period)
        begin
            timer_next.cnt  = 8'h01;
            timer_next.tick = 1'b1;
        end
        else
        begin
            timer_next.cnt = timer_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            timer_reg <= '0;
        end
        else
        begin
            timer_reg <= timer_next;
        end
    end

    assign link.tick = timer_reg.tick;
endmodule
`default_nettype wire

//--- logic/spc_cal_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
module spc_cal_port
    import spc_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic        i_serial_io_pin,
    output logic             o_serial_io_pin,
    output logic             o_serial_io_pin_oe_n,
    input  wire logic [7:0]  i_lock_byte,
    input  wire logic        i_lock_override,
    input  wire logic [7:0]  i_temp_pointer,
    input  wire logic [7:0]  i_readback_data,
    output logic [15:0]      o_configuration_word,
    output logic [15:0]      o_data_hold_latch,
    output logic [3:0]       o_iface_read_pointer,
    output logic [7:0]       o_learned_bit_period,
    output logic             o_cmd_strobe,
    output logic [3:0]       o_cmd_code,
    output logic [9:0]       o_offset_lut_addr,
    output logic [9:0]       o_span_lut_addr,
    output logic [1:0]       o_clip_select,
    output logic             o_input_polarity_invert,
    output logic             o_coarse_offset_polarity,
    output logic [2:0]       o_coarse_offset_magnitude,
    output logic             o_coarse_offset_active,
    output logic [7:0]       o_gain_vv,
    output logic             o_offset_dac_polarity,
    output logic             o_offset_tc_polarity
);
    typedef struct packed
    {
        spc_state_e  state;
        logic [1:0]  sync;
        logic        pin_q;
        logic [8:0]  learn_cnt;
        logic [7:0]  period;
        logic [3:0]  bitn;
        logic [3:0]  ticks;
        logic [7:0]  shift;
        logic [9:0]  tx_frame;
        logic [15:0] hold;
        logic [15:0] config_word;
        logic [3:0]  rd_ptr;
        logic        cmd_strobe;
        logic [3:0]  cmd_code;
        logic        drive;
        logic        dout;
        logic [7:0]  half_cnt;
    } spc_state_s;

    spc_state_s s_reg;
    spc_state_s s_next;
    spc_link_if link ();

    spc_bit_timer u_timer
    (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .link   (link)
    );

    function automatic logic [9:0] lut_addr(input logic [7:0] ptr,
                                             input logic [9:0] low_base,
                                             input logic [9:0] high_base);
        logic [7:0] off;
        off = ptr - `SPC_PTR_SPLIT;
        if (ptr < `SPC_PTR_SPLIT)
            lut_addr = low_base + {1'b0, ptr, 1'b0};
        else
            lut_addr = high_base + {1'b0, off, 1'b0};
    endfunction

    logic enabled;
    logic pin;
    logic fall;
    assign enabled = (i_lock_byte == 8'h00) || i_lock_override;
    assign pin     = s_reg.sync[1];
    assign fall    = s_reg.pin_q && !pin;

    always_comb
    begin
        s_next            = s_reg;
        s_next.sync       = {s_reg.sync[0], i_serial_io_pin};
        s_next.pin_q      = pin;
        s_next.cmd_strobe = 1'b0;
        link.restart      = 1'b0;
        link.period       = s_reg.period;
        case (s_reg.state)
            SPC_RX_LEARN_IDLE:
            begin
                s_next.learn_cnt = 9'h000;
                if (fall && enabled)
                    s_next.state = SPC_RX_LEARN_START;
            end
            SPC_RX_LEARN_START:
            begin
                // Time the start bit up to the rise of bit 0; skip the rest of the byte
                if (pin)
                begin
                    s_next.period = (s_reg.learn_cnt >= 9'h0ff) ? 8'hff
                        : s_reg.learn_cnt[7:0] + 8'h01;
                    link.restart  = 1'b1;
                    s_next.state  = SPC_TX_GAP;
                    s_next.ticks  = 4'd3;
                end
                else if (s_reg.learn_cnt != 9'h1ff)
                    s_next.learn_cnt = s_reg.learn_cnt + 9'h001;
            end
            SPC_RX_IDLE:
            begin
                if (!enabled)
                    s_next.state = SPC_RX_LEARN_IDLE;
                else if (fall)
                begin
                    s_next.half_cnt = 8'h03;
                    s_next.bitn     = 4'h0;
                    s_next.state    = SPC_RX_DATA;
                end
            end
            SPC_RX_DATA:
            begin
                // Head start of 3 covers sync and tick delay: mid-bit
                if (s_reg.half_cnt != 8'h00)
                begin
                    if (s_reg.half_cnt >= {1'b0, s_reg.period[7:1]})
                    begin
                        s_next.half_cnt = 8'h00;
                        link.restart    = 1'b1;
                    end
                    else
                        s_next.half_cnt = s_reg.half_cnt + 8'h01;
                end
                else if (link.tick)
                begin
                    s_next.shift = {pin, s_reg.shift[7:1]};
                    s_next.bitn  = s_reg.bitn + 4'h1;
                    if (s_reg.bitn == 4'h7)
                        s_next.state = SPC_RX_STOP;
                end
            end
            SPC_RX_STOP:
            begin
                if (link.tick)
                begin
                    s_next.state = SPC_RX_IDLE;
                    if (pin)
                    begin
                        if (s_reg.shift == `SPC_RELEARN_BYTE ||
                            s_reg.shift[3:0] == `SPC_ADDR_RELEARN)
                            s_next.state = SPC_RX_LEARN_IDLE;
                        else
                        begin
                            case (s_reg.shift[3:0])
                                4'h0, 4'h1, 4'h2, 4'h3:
                                    s_next.hold[s_reg.shift[1:0]*4 +: 4]
                                        = s_reg.shift[7:4];
                                `SPC_ADDR_RDPTR:
                                    s_next.rd_ptr = s_reg.shift[7:4];
                                `SPC_ADDR_LOGIC_CMD:
                                begin
                                    s_next.cmd_strobe = 1'b1;
                                    s_next.cmd_code   = s_reg.shift[7:4];
                                    if (s_reg.shift[7:4] == `SPC_CMD_LOAD_CAL)
                                        s_next.config_word = s_reg.hold;
                                    if (s_reg.shift[7:4] == `SPC_CMD_READ_CAL)
                                        s_next.hold = s_reg.config_word;
                                    if (s_reg.shift[7:4] == `SPC_CMD_READBACK)
                                    begin
                                        s_next.ticks = 4'd0;
                                        s_next.state = SPC_TX_WAIT;
                                    end
                                end
                                default:
                                    s_next.state = SPC_RX_IDLE;
                            endcase
                        end
                    end
                end
            end
            SPC_TX_WAIT:
            begin
                // One byte time before driving, host released by then
                if (link.tick)
                begin
                    s_next.ticks = s_reg.ticks + 4'h1;
                    if (s_reg.ticks == `SPC_FRAME_BITS - 4'd1)
                    begin
                        s_next.drive = 1'b1;
                        s_next.dout  = 1'b1;
                        s_next.tx_frame = {1'b1, i_readback_data, 1'b0};
                        s_next.state = SPC_TX_PRE;
                    end
                end
            end
            SPC_TX_PRE:
            begin
                if (link.tick)
                begin
                    s_next.dout  = s_reg.tx_frame[0];
                    s_next.tx_frame = {1'b1, s_reg.tx_frame[9:1]};
                    s_next.bitn  = 4'h0;
                    s_next.state = SPC_TX_BITS;
                end
            end
            SPC_TX_BITS:
            begin
                if (link.tick)
                begin
                    s_next.bitn = s_reg.bitn + 4'h1;
                    s_next.dout = s_reg.tx_frame[0];
                    s_next.tx_frame = {1'b1, s_reg.tx_frame[9:1]};
                    if (s_reg.bitn == `SPC_FRAME_BITS - 4'd1)
                    begin
                        s_next.drive = 1'b0;
                        s_next.ticks = 4'd0;
                        s_next.state = SPC_TX_GAP;
                    end
                end
            end
            SPC_TX_GAP:
            begin
                // Ignore the line for one byte time after a reply, seven bit times after learning
                if (link.tick)
                begin
                    s_next.ticks = s_reg.ticks + 4'h1;
                    if (s_reg.ticks == `SPC_FRAME_BITS - 4'd1)
                        s_next.state = SPC_RX_IDLE;
                end
            end
            default:
                s_next.state = SPC_RX_LEARN_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            s_reg             <= '0;
            s_reg.sync        <= 2'b11;
            s_reg.pin_q       <= 1'b1;
            s_reg.dout        <= 1'b1;
            s_reg.config_word <= `SPC_CFG_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign o_serial_io_pin      = s_reg.dout;
    assign o_serial_io_pin_oe_n = !s_reg.drive;
    assign o_configuration_word = s_reg.config_word;
    assign o_data_hold_latch    = s_reg.hold;
    assign o_iface_read_pointer = s_reg.rd_ptr;
    assign o_learned_bit_period = s_reg.period;
    assign o_cmd_strobe         = s_reg.cmd_strobe;
    assign o_cmd_code           = s_reg.cmd_code;
    assign o_offset_lut_addr    = lut_addr(i_temp_pointer,
        `SPC_OFFSET_DAC_VALUE_LOW_BASE, `SPC_OFFSET_DAC_VALUE_HIGH_BASE);
    assign o_span_lut_addr      = lut_addr(i_temp_pointer,
        `SPC_SPAN_LOW_BASE, `SPC_SPAN_HIGH_BASE);
    assign o_clip_select = s_reg.config_word[`SPC_CFG_CLIP_HI:`SPC_CFG_CLIP_LO];
    assign o_input_polarity_invert  = s_reg.config_word[`SPC_CFG_INV];
    assign o_coarse_offset_polarity = s_reg.config_word[`SPC_CFG_COARSE_OFFSET_POLARITY];
    assign o_coarse_offset_magnitude =
        s_reg.config_word[`SPC_CFG_IRO_HI:`SPC_CFG_IRO_LO];
    assign o_coarse_offset_active = (o_coarse_offset_magnitude != 3'h0);
    assign o_gain_vv = `SPC_GAIN_BASE + `SPC_GAIN_STEP *
        {4'h0, s_reg.config_word[`SPC_CFG_GAIN_HI:`SPC_CFG_GAIN_LO]};
    assign o_offset_dac_polarity = s_reg.config_word[`SPC_CFG_OFFSET_DAC_POLARITY];
    assign o_offset_tc_polarity  = s_reg.config_word[`SPC_CFG_OTC_SIGN];
endmodule
`default_nettype wire

//--- testbench/spc_cal_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spc_cal_port_checker
    import spc_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_temp_pointer,
    input  wire logic        o_serial_io_pin,
    input  wire logic        o_serial_io_pin_oe_n,
    input  wire logic [15:0] o_configuration_word,
    input  wire logic [7:0]  o_learned_bit_period,
    input  wire logic        o_cmd_strobe,
    input  wire logic [3:0]  o_cmd_code,
    input  wire logic [9:0]  o_offset_lut_addr,
    input  wire logic [9:0]  o_span_lut_addr,
    input  wire logic [1:0]  o_clip_select,
    input  wire logic        o_input_polarity_invert,
    input  wire logic        o_coarse_offset_polarity,
    input  wire logic [2:0]  o_coarse_offset_magnitude,
    input  wire logic [7:0]  o_gain_vv,
    input  wire logic        o_offset_dac_polarity,
    input  wire logic        o_offset_tc_polarity
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    logic [7:0] hi_cnt_reg;
    logic       tx_seen_reg;
    logic [9:0] dbl;
    assign dbl = {2'b00, i_temp_pointer[6:0], 1'b0};
    // Counts the high preamble before the first low of a reply
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn || o_serial_io_pin_oe_n)
        begin
            hi_cnt_reg  <= 8'h00;
            tx_seen_reg <= 1'b0;
        end
        else
        begin
            if (o_serial_io_pin && !tx_seen_reg)
                hi_cnt_reg <= hi_cnt_reg + 8'h01;
            if (!o_serial_io_pin)
                tx_seen_reg <= 1'b1;
        end
    end
    cmd_single_pulse_a: assert property (o_cmd_strobe |=> !o_cmd_strobe)
        else $error("strobe too long");
    released_high_a: assert property (o_serial_io_pin_oe_n |-> o_serial_io_pin)
        else $error("released pin not high");
    reset_state_a: assert property ($rose(i_rstn) |-> o_serial_io_pin_oe_n
        && o_configuration_word == 16'h0 && o_learned_bit_period == 8'h0)
        else $error("bad state after reset");
    gain_map_a: assert property ($stable(o_configuration_word) |-> o_gain_vv
        == 8'd39 + 8'd13 * {4'h0, o_configuration_word[5:2]})
        else $error("gain wrong");
    fields_map_a: assert property ($stable(o_configuration_word)
        |-> {o_clip_select, o_input_polarity_invert, o_coarse_offset_polarity,
        o_coarse_offset_magnitude, o_offset_dac_polarity, o_offset_tc_polarity}
        == {o_configuration_word[12:6], o_configuration_word[1:0]})
        else $error("config fields wrong");
    lut_low_a: assert property (i_temp_pointer < 8'h80 |->
        o_offset_lut_addr == dbl && o_span_lut_addr == 10'h200 + dbl)
        else $error("low lookup address wrong");
    lut_high_a: assert property (i_temp_pointer inside {[8'h80:8'haf]} |->
        o_offset_lut_addr == 10'h100 + dbl && o_span_lut_addr == 10'h1a0 + dbl)
        else $error("high lookup address wrong");
    preamble_bit_a: assert property ($fell(o_serial_io_pin) && !tx_seen_reg
        && !o_serial_io_pin_oe_n |-> hi_cnt_reg == o_learned_bit_period)
        else $error("preamble not one bit");
    stop_release_a: assert property ($rose(o_serial_io_pin_oe_n)
        |-> $past(o_serial_io_pin))
        else $error("released before high stop");
    reply_wait_a: assert property (o_cmd_strobe ##1 o_cmd_code == 4'h5
        |-> o_serial_io_pin_oe_n [*8])
        else $error("reply driven too early");
    readback_c: cover property ($fell(o_serial_io_pin_oe_n));
    cfg_load_c: cover property (o_cmd_strobe ##1 o_cmd_code == 4'h0);
    relearn_c: cover property ($changed(o_learned_bit_period));
endmodule
bind spc_cal_port spc_cal_port_checker i_spc_cal_port_checker (
    .i_mclk, .i_rstn, .i_temp_pointer, .o_serial_io_pin,
    .o_serial_io_pin_oe_n, .o_configuration_word, .o_learned_bit_period,
    .o_cmd_strobe, .o_cmd_code, .o_offset_lut_addr, .o_span_lut_addr,
    .o_clip_select, .o_input_polarity_invert, .o_coarse_offset_polarity,
    .o_coarse_offset_magnitude, .o_gain_vv, .o_offset_dac_polarity,
    .o_offset_tc_polarity
);
`default_nettype wire

//--- testbench/spc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spc_host_model (
    input  wire logic i_mclk,
    input  wire logic i_line,
    output var logic  o_drive,
    output var logic  o_en
);
    int bit_cyc = 8;
    initial
    begin
        o_drive = 1'b1;
        o_en    = 1'b1;
    end
    // Start low, LSB first, stop at the level asked for
    task automatic send_byte(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            o_drive <= f[i];
            repeat (bit_cyc) @(posedge i_mclk);
        end
        if (!stop)
        begin
            o_drive <= 1'b1;
            repeat (bit_cyc) @(posedge i_mclk);
        end
    endtask
    // Lets go of the line, samples the reply mid-bit, then drives high
    task automatic recv_byte(output logic [7:0] b, output int w,
                             output logic s);
        o_en <= 1'b0;
        w = 0;
        while (i_line !== 1'b0 && w < 400)
        begin
            @(posedge i_mclk);
            w++;
        end
        repeat (bit_cyc / 2) @(posedge i_mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_cyc) @(posedge i_mclk);
            b[i] = i_line;
        end
        repeat (bit_cyc) @(posedge i_mclk);
        s = i_line;
        repeat (bit_cyc) @(posedge i_mclk);
        o_en <= 1'b1;
    endtask
endmodule
`default_nettype wire

//--- testbench/spc_cal_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module spc_cal_port_test;
    import spc_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_rstn;
    logic        line;
    logic        dev_out;
    logic        dev_oe_n;
    logic [7:0]  i_lock_byte;
    logic        i_lock_override;
    logic [7:0]  i_temp_pointer;
    logic [7:0]  i_readback_data;
    logic [15:0] cfg;
    logic [15:0] hold;
    logic [3:0]  rd_ptr;
    logic [7:0]  period;
    logic [9:0]  off_addr;
    logic [9:0]  span_addr;
    logic [1:0]  clip;
    logic [2:0]  mag;
    logic [7:0]  gain;
    logic        act;
    logic        host_drv;
    logic        host_en;
    int          err_count = 0;
    int          checks = 0;
    always #50 i_mclk = ~i_mclk;
    // Pull-up holds the line high when nobody drives it
    assign line = !dev_oe_n ? dev_out : (host_en ? host_drv : 1'b1);
    spc_cal_port i_spc_cal_port (
        .i_mclk, .i_rstn, .i_serial_io_pin(line), .o_serial_io_pin(dev_out),
        .o_serial_io_pin_oe_n(dev_oe_n), .i_lock_byte, .i_lock_override,
        .i_temp_pointer, .i_readback_data, .o_configuration_word(cfg),
        .o_data_hold_latch(hold), .o_iface_read_pointer(rd_ptr),
        .o_learned_bit_period(period), .o_cmd_strobe(), .o_cmd_code(),
        .o_offset_lut_addr(off_addr), .o_span_lut_addr(span_addr),
        .o_clip_select(clip), .o_input_polarity_invert(),
        .o_coarse_offset_polarity(), .o_coarse_offset_magnitude(mag),
        .o_coarse_offset_active(act), .o_gain_vv(gain),
        .o_offset_dac_polarity(), .o_offset_tc_polarity()
    );
    spc_host_model i_spc_host_model (
        .i_mclk, .i_line(line), .o_drive(host_drv), .o_en(host_en)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %0t: %s %h vs %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [7:0] gain_of(input logic [3:0] c);
        return 8'd39 + 8'd13 * {4'h0, c};
    endfunction
    function automatic logic [9:0] lut_of(input logic [7:0] p,
                                          input logic span);
        logic [9:0] d;
        d = {2'b00, p[6:0], 1'b0};
        if (p < 8'h80)
            return (span ? 10'h200 : 10'h000) + d;
        return (span ? 10'h1a0 : 10'h100) + d;
    endfunction
    task automatic tx(input logic [7:0] b);
        i_spc_host_model.send_byte(b, 1'b1);
    endtask
    task automatic idle_byte;
        repeat (10 * i_spc_host_model.bit_cyc + 8) @(posedge i_mclk);
    endtask
    task automatic learn(input int bc);
        i_spc_host_model.bit_cyc = bc;
        tx(8'h01);
        chk(16'(period >= bc - 1 && period <= bc + 1), 16'h1, "period");
        idle_byte();
    endtask
    task automatic load_hold(input logic [15:0] h);
        for (int n = 0; n < 4; n++)
            tx({h[4*n +: 4], 4'(n)});
    endtask
    task automatic chk_nib(input logic [3:0] v);
        chk({12'h0, hold[3:0]}, {12'h0, v}, "nibble");
    endtask
    initial
    begin
        logic [15:0] h;
        logic [7:0]  b;
        logic [7:0]  lp [4];
        logic [3:0]  p;
        logic        s;
        int          w;
        w = $urandom(32'hf8e3);
        lp = '{8'h00, 8'h7f, 8'h80, 8'haf};
        i_rstn          <= 1'b0;
        i_lock_byte     <= 8'h00;
        i_lock_override <= 1'b0;
        i_temp_pointer  <= 8'h00;
        i_readback_data <= 8'h00;
        repeat (16) @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_mclk);
        chk({15'h0, dev_oe_n}, 16'h1, "released");
        chk(cfg, 16'h0000, "config reset");
        learn(8);
        for (int k = 0; k < 6; k++)
        begin
            i_temp_pointer <= (k < 4) ? lp[k] : 8'($urandom_range(175));
            repeat (2) @(posedge i_mclk);
            chk({6'h0, off_addr}, {6'h0, lut_of(i_temp_pointer, 0)}, "off");
            chk({6'h0, span_addr}, {6'h0, lut_of(i_temp_pointer, 1)}, "span");
        end
        for (int k = 0; k < 4; k++)
        begin
            h = (k == 0) ? 16'h1fff : (k == 1) ? 16'h0 : {3'h0, 13'($urandom)};
            load_hold(h);
            chk(hold, h, "hold");
            tx(8'h09);
            chk(cfg, h, "config");
            chk({8'h0, gain}, {8'h0, gain_of(h[5:2])}, "gain");
            chk({14'h0, clip}, {14'h0, h[12:11]}, "clip");
            chk({13'h0, mag}, {13'h0, h[8:6]}, "magnitude");
            chk({15'h0, act}, {15'h0, h[8:6] != 3'h0}, "active");
        end
        load_hold(16'($urandom));
        tx(8'h39);
        chk(hold, h, "config to hold");
        p = 4'($urandom);
        tx({p, 4'h8});
        chk({12'h0, rd_ptr}, {12'h0, p}, "pointer");
        i_readback_data <= 8'($urandom);
        tx(8'h59);
        i_spc_host_model.recv_byte(b, w, s);
        chk({8'h0, b}, {8'h0, i_readback_data}, "reply");
        chk({15'h0, s}, 16'h1, "reply stop");
        chk(16'(w >= 80 && w <= 96), 16'h1, "turnaround");
        idle_byte();
        tx({4'hc, 4'h0});
        chk_nib(4'hc);
        i_spc_host_model.send_byte({4'h3, 4'h0}, 1'b0);
        chk_nib(4'hc);
        tx(8'hff);
        learn(12);
        tx({4'h9, 4'h0});
        chk_nib(4'h9);
        tx(8'h3f);
        learn(8);
        i_lock_byte <= 8'h5a;
        repeat (4) @(posedge i_mclk);
        tx({4'h7, 4'h0});
        chk_nib(4'h9);
        i_lock_override <= 1'b1;
        repeat (4) @(posedge i_mclk);
        learn(8);
        tx({4'h7, 4'h0});
        chk_nib(4'h7);
        stop_test();
    end
endmodule
`default_nettype wire
